// File: verilog/asc_defines.svh
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// register offsets on the control port
`define ASC_REG_CH8     8'h12
`define ASC_REG_CFG_A   8'h13
`define ASC_REG_RATE    8'h14

// reset values
`define ASC_RST_CH8     7'h07
`define ASC_RST_CFG_A   8'h02
`define ASC_RST_RATE    8'h48

// field positions
`define ASC_B_LINE      6
`define ASC_B_ROLE      7
`define ASC_B_AUTO_OFF  6
`define ASC_B_PLL_BYP   5
`define ASC_B_GATE      4
`define ASC_B_FAMILY    3

// highest legal codes
`define ASC_RATE_MAX    4'h8
`define ASC_RATIO_MAX   4'hC

// core clock rate in Hz, and 44.1k family scale 147/160
`define ASC_CLK_HZ      33'h005F5E100
`define ASC_FAM_NUM     32'h00000093
`define ASC_FAM_DEN     32'h000000A0

`endif

// File: verilog/asc_pkg.sv
package asc_pkg;

    typedef enum logic [1:0] {
        ASC_IDLE = 2'b01,
        ASC_RUN  = 2'b10
    } asc_frame_type;

    // nominal 48k family rate in Hz, zero for reserved codes
    function automatic logic [31:0] asc_rate_hz(input logic [3:0] code);
        case (code)
            4'h0:    asc_rate_hz = 32'h00001F40;
            4'h1:    asc_rate_hz = 32'h00003E80;
            4'h2:    asc_rate_hz = 32'h00005DC0;
            4'h3:    asc_rate_hz = 32'h00007D00;
            4'h4:    asc_rate_hz = 32'h0000BB80;
            4'h5:    asc_rate_hz = 32'h00017700;
            4'h6:    asc_rate_hz = 32'h0002EE00;
            4'h7:    asc_rate_hz = 32'h0005DC00;
            4'h8:    asc_rate_hz = 32'h000BB800;
            default: asc_rate_hz = 32'h00000000;
        endcase
    endfunction

    // bit clocks per frame, zero for reserved codes
    function automatic logic [11:0] asc_ratio(input logic [3:0] code);
        case (code)
            4'h0:    asc_ratio = 12'h010;
            4'h1:    asc_ratio = 12'h018;
            4'h2:    asc_ratio = 12'h020;
            4'h3:    asc_ratio = 12'h030;
            4'h4:    asc_ratio = 12'h040;
            4'h5:    asc_ratio = 12'h060;
            4'h6:    asc_ratio = 12'h080;
            4'h7:    asc_ratio = 12'h0C0;
            4'h8:    asc_ratio = 12'h100;
            4'h9:    asc_ratio = 12'h180;
            4'hA:    asc_ratio = 12'h200;
            4'hB:    asc_ratio = 12'h400;
            4'hC:    asc_ratio = 12'h800;
            default: asc_ratio = 12'h000;
        endcase
    endfunction

    // fixed master clock frequency in Hz
    function automatic logic [31:0] asc_mclk_hz(input logic [2:0] code);
        unique case (code)
            3'h0: asc_mclk_hz = 32'h00B71B00;
            3'h1: asc_mclk_hz = 32'h00BB8000;
            3'h2: asc_mclk_hz = 32'h00C65D40;
            3'h3: asc_mclk_hz = 32'h00F42400;
            3'h4: asc_mclk_hz = 32'h0124F800;
            3'h5: asc_mclk_hz = 32'h012C4B00;
            3'h6: asc_mclk_hz = 32'h016E3600;
            3'h7: asc_mclk_hz = 32'h01770000;
        endcase
    endfunction

    // master clock to frame ratio
    function automatic logic [11:0] asc_mclk_ratio(input logic [2:0] code);
        unique case (code)
            3'h0: asc_mclk_ratio = 12'h040;
            3'h1: asc_mclk_ratio = 12'h100;
            3'h2: asc_mclk_ratio = 12'h180;
            3'h3: asc_mclk_ratio = 12'h200;
            3'h4: asc_mclk_ratio = 12'h300;
            3'h5: asc_mclk_ratio = 12'h400;
            3'h6: asc_mclk_ratio = 12'h600;
            3'h7: asc_mclk_ratio = 12'h900;
        endcase
    endfunction

endpackage

// File: verilog/asc_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface asc_stream_if #(
    parameter int W = 32
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: verilog/asc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module asc_fifo
    import asc_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 8
)
(
    input  wire logic   core_clk,
    input  wire logic   rst,
    asc_stream_if.snk   in_s,
    asc_stream_if.src   out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;

    // full and empty come straight from the fill count
    wire push = in_s.valid && in_s.ready;
    wire pop  = out_s.valid && out_s.ready;
    assign in_s.ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data  = mem[rp_r];

    // storage has no reset, only the pointers and the fill count do
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wp_r] <= in_s.data;
    end

    // pointer wrap handled by explicit compare so DEPTH need not be 2^n
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: verilog/asc_top.sv
// Operation
// - line bit picks primary or secondary output
// - slot field places channel eight in frame
// - role bit: clocks are inputs or generated
// - auto bit selects derived or custom clocking
// - auto mode uses or bypasses the PLL
// - gate bit silences generated clocks
// - family bit picks 48k or 44.1k rates
// - master clock code gives PLL reference when clocks are generated, zero as target
// - rate code maps nine rates, rest reserved
// - ratio code maps thirteen ratios, rest reserved
// - target auto mode ignores rate, and uses ratio only for the left/right slot split
// - spec mode derives reference from frame ratio
`timescale 1ns/10ps
`default_nettype none
`include "asc_defines.svh"
module asc_top
    import asc_pkg::*;
#(
    parameter int WORD_W     = 32,
    parameter int FIFO_DEPTH = 8
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic              smp_valid,
    output logic                   smp_ready,
    input  wire logic [WORD_W-1:0] smp_data,
    input  wire logic              format_is_tdm,
    input  wire logic              master_clock_spec_mode,
    input  wire logic [2:0]        mclk_frame_ratio_code,
    input  wire logic              bclk_in,
    input  wire logic              fsync_in,
    output logic                   bclk_out,
    output logic                   bclk_oe,
    output logic                   fsync_out,
    output logic                   fsync_oe,
    output logic                   primary_serial_out_pin,
    output logic                   primary_oe,
    output logic                   general_io_pin_one_out,
    output logic                   general_io_pin_one_oe,
    output logic                   pll_enable,
    output logic                   custom_clock_mode,
    output logic                   cfg_invalid,
    output logic [31:0]            pll_ref_hz
);
    logic [6:0]        ch8_r;
    logic [7:0]        cfg_a_r;
    logic [7:0]        rate_r;
    logic [7:0]        rdata_r;
    logic [32:0]       acc_r;
    logic [32:0]       acc_nxt;
    logic              bclk_gen_r;
    logic              fsync_gen_r;
    logic              bclk_s1_r;
    logic              bclk_s2_r;
    logic              bclk_d_r;
    logic              fsync_s1_r;
    logic              fsync_s2_r;
    logic              fs_prev_r;
    logic [11:0]       cnt_r;
    logic [11:0]       cnt_nxt;
    asc_frame_type     st_r;
    asc_frame_type     st_nxt;
    logic [WORD_W-1:0] word_r;
    logic              data_bit_r;
    logic              slot_on_r;
    logic              pll_en_r;
    logic              custom_r;
    logic              bad_r;
    logic [31:0]       ref_r;

    asc_stream_if #(.W(WORD_W)) in_if ();
    asc_stream_if #(.W(WORD_W)) out_if ();

    // register decode; bit 7 of the slot register is reserved, reads zero
    wire wr_ch8  = reg_wr && (reg_addr == `ASC_REG_CH8);
    wire wr_cfg  = reg_wr && (reg_addr == `ASC_REG_CFG_A);
    wire wr_rate = reg_wr && (reg_addr == `ASC_REG_RATE);
    wire [7:0] rd_mux = (reg_addr == `ASC_REG_CH8)   ? {1'b0, ch8_r} :
                        (reg_addr == `ASC_REG_CFG_A) ? cfg_a_r :
                        (reg_addr == `ASC_REG_RATE)  ? rate_r : 8'h00;

    // field views
    wire       line_sel   = ch8_r[`ASC_B_LINE];
    wire [5:0] slot       = ch8_r[5:0];
    wire       role       = cfg_a_r[`ASC_B_ROLE];
    wire       auto_off   = cfg_a_r[`ASC_B_AUTO_OFF];
    wire       pll_byp    = cfg_a_r[`ASC_B_PLL_BYP];
    wire       gate       = cfg_a_r[`ASC_B_GATE];
    wire       family     = cfg_a_r[`ASC_B_FAMILY];
    wire [2:0] mclk_code  = cfg_a_r[2:0];
    wire [3:0] rate_code  = rate_r[7:4];
    wire [3:0] ratio_code = rate_r[3:0];

    wire prog_used = role || auto_off;
    wire code_bad  = (rate_code > `ASC_RATE_MAX) || (ratio_code > `ASC_RATIO_MAX);
    wire cfg_bad   = prog_used && code_bad;

    wire [31:0] base_hz = asc_rate_hz(rate_code);
    wire [31:0] fam_hz  = 32'(base_hz * `ASC_FAM_NUM) / `ASC_FAM_DEN;
    wire [31:0] fs_hz   = family ? fam_hz : base_hz;
    wire [11:0] ratio   = asc_ratio(ratio_code);
    wire [11:0] half    = ratio >> 1;

    // bit clock rate from rate times ratio
    wire        gen_en   = role && !cfg_bad;
    wire [31:0] bit_hz   = 32'(fs_hz * {20'h00000, ratio});
    wire [32:0] nco_step = {bit_hz, 1'b0};
    wire [32:0] nco_sum  = acc_r + nco_step;
    wire [32:0] nco_left = nco_sum - `ASC_CLK_HZ;
    wire        nco_wrap = gen_en && (nco_sum >= `ASC_CLK_HZ);
    wire        gen_fall = nco_wrap && bclk_gen_r;

    // phase accumulator; fractional rates average out, jitter is one core cycle
    always_comb
    begin
        acc_nxt = nco_sum;
        if (!gen_en)
            acc_nxt = '0;
        else if (nco_wrap)
            acc_nxt = (nco_left >= `ASC_CLK_HZ) ? '0 : nco_left;
    end

    wire tgt_fall = !role && bclk_d_r && !bclk_s2_r;
    wire bit_tick = role ? gen_fall : tgt_fall;
    wire idle     = (st_r == ASC_IDLE);
    // a ratio shortened mid-frame ends the frame at once instead of running on
    wire last_bit = (cnt_r >= ratio - 12'h001);
    wire frame_go = role ? (last_bit || idle) : (fsync_s2_r && !fs_prev_r);
    wire load     = bit_tick && frame_go;

    // frame state; target frames lapse if fsync stops arriving
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            ASC_IDLE:
            begin
                if (frame_go)
                begin
                    st_nxt  = ASC_RUN;
                    cnt_nxt = 12'h000;
                end
            end
            ASC_RUN:
            begin
                if (frame_go)
                    cnt_nxt = 12'h000;
                else if (cnt_r == 12'hFFF)
                    st_nxt = ASC_IDLE;
                else
                    cnt_nxt = cnt_r + 12'h001;
            end
        endcase
    end

    wire [12:0] slot_tdm   = 13'(slot * WORD_W);
    wire [12:0] slot_lr    = 13'(slot[4:0] * WORD_W) + (slot[5] ? {1'b0, half} : 13'h0000);
    wire [12:0] slot_start = format_is_tdm ? slot_tdm : slot_lr;
    wire [12:0] pos_nxt    = {1'b0, cnt_nxt};
    wire        in_slot    = (st_nxt == ASC_RUN) && (pos_nxt >= slot_start) &&
                             (pos_nxt < slot_start + 13'(WORD_W));
    wire [12:0] bit_off    = pos_nxt - slot_start;

    // an empty fifo at frame start sends a zero word rather than stalling
    wire [WORD_W-1:0] fresh    = out_if.valid ? out_if.data : '0;
    wire [WORD_W-1:0] word_sel = load ? fresh : word_r;
    wire [WORD_W-1:0] word_sh  = word_sel << bit_off;

    assign in_if.valid  = smp_valid;
    assign in_if.data   = smp_data;
    assign smp_ready    = in_if.ready;
    assign out_if.ready = load;

    asc_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .in_s     (in_if),
        .out_s    (out_if)
    );

    wire [31:0] spec_hz = 32'(fs_hz * {20'h00000, asc_mclk_ratio(mclk_frame_ratio_code)});
    wire [31:0] ref_nxt = !role ? 32'h00000000 :
                          master_clock_spec_mode ? spec_hz : asc_mclk_hz(mclk_code);

    // control registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ch8_r   <= `ASC_RST_CH8;
            cfg_a_r <= `ASC_RST_CFG_A;
            rate_r  <= `ASC_RST_RATE;
            rdata_r <= 8'h00;
        end
        else
        begin
            if (wr_ch8)
                ch8_r <= reg_wdata[6:0];
            if (wr_cfg)
                cfg_a_r <= reg_wdata;
            if (wr_rate)
                rate_r <= reg_wdata;
            if (reg_rd)
                rdata_r <= rd_mux;
        end
    end

    // pin synchronisers, second stage feeds the edge logic
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bclk_s1_r  <= 1'b0;
            bclk_s2_r  <= 1'b0;
            bclk_d_r   <= 1'b0;
            fsync_s1_r <= 1'b0;
            fsync_s2_r <= 1'b0;
        end
        else
        begin
            bclk_s1_r  <= bclk_in;
            bclk_s2_r  <= bclk_s1_r;
            bclk_d_r   <= bclk_s2_r;
            fsync_s1_r <= fsync_in;
            fsync_s2_r <= fsync_s1_r;
        end
    end

    // clock generation and framing
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            acc_r       <= '0;
            bclk_gen_r  <= 1'b0;
            fsync_gen_r <= 1'b0;
            fs_prev_r   <= 1'b0;
            st_r        <= ASC_IDLE;
            cnt_r       <= 12'h000;
            word_r      <= '0;
            data_bit_r  <= 1'b0;
            slot_on_r   <= 1'b0;
        end
        else if (role && !gen_en)
        begin
            acc_r       <= '0;
            bclk_gen_r  <= 1'b0;
            fsync_gen_r <= 1'b0;
            st_r        <= ASC_IDLE;
            slot_on_r   <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            if (nco_wrap)
                bclk_gen_r <= !bclk_gen_r;
            if (bit_tick)
            begin
                fs_prev_r   <= fsync_s2_r;
                st_r        <= st_nxt;
                cnt_r       <= cnt_nxt;
                word_r      <= word_sel;
                fsync_gen_r <= role && (format_is_tdm ? (cnt_nxt == 12'h000) : (cnt_nxt < half));
                data_bit_r  <= in_slot && word_sh[WORD_W-1];
                slot_on_r   <= in_slot;
            end
        end
    end

    // status outputs, one cycle behind the registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pll_en_r <= 1'b0;
            custom_r <= 1'b0;
            bad_r    <= 1'b0;
            ref_r    <= 32'h00000000;
        end
        else
        begin
            pll_en_r <= !auto_off && !pll_byp;
            custom_r <= auto_off;
            bad_r    <= cfg_bad;
            ref_r    <= ref_nxt;
        end
    end

    assign reg_rdata              = rdata_r;
    assign bclk_out               = bclk_gen_r && !gate;
    assign fsync_out              = fsync_gen_r && !gate;
    assign bclk_oe                = role;
    assign fsync_oe               = role;
    assign primary_serial_out_pin = data_bit_r;
    assign primary_oe             = slot_on_r && !line_sel;
    assign general_io_pin_one_out = data_bit_r;
    assign general_io_pin_one_oe  = slot_on_r && line_sel;
    assign pll_enable             = pll_en_r;
    assign custom_clock_mode      = custom_r;
    assign cfg_invalid            = bad_r;
    assign pll_ref_hz             = ref_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_line;
        general_io_pin_one_oe |-> line_sel && !primary_oe;
    endproperty
    a_line: assert property (p_line) else $error("secondary drives with line bit low");

    property p_slot;
        (bit_tick && in_slot) |=> (primary_oe || general_io_pin_one_oe);
    endproperty
    a_slot: assert property (p_slot) else $error("slot bit not driven");

    property p_role;
        bclk_oe == role && fsync_oe == role;
    endproperty
    a_role: assert property (p_role) else $error("clock pin drive disagrees with role");

    property p_auto;
        ##1 custom_clock_mode == $past(auto_off);
    endproperty
    a_auto: assert property (p_auto) else $error("custom mode flag wrong");

    property p_pll;
        (!auto_off && pll_byp) |=> !pll_enable;
    endproperty
    a_pll: assert property (p_pll) else $error("pll left on when bypassed");

    property p_gate;
        (role && gate) [*2] |-> !bclk_out && !fsync_out;
    endproperty
    a_gate: assert property (p_gate) else $error("gated clock still toggles");

    property p_family;
        (rate_code == 4'h4 && family) |-> fs_hz == 32'h0000AC44;
    endproperty
    a_family: assert property (p_family) else $error("44.1k family rate wrong");

    property p_mclk;
        (role && !master_clock_spec_mode && mclk_code == 3'h7) |=> pll_ref_hz == 32'h01770000;
    endproperty
    a_mclk: assert property (p_mclk) else $error("master clock code 7 wrong");

    property p_rate_rsv;
        (role && rate_code > 4'h8) |=> cfg_invalid && !bclk_gen_r;
    endproperty
    a_rate_rsv: assert property (p_rate_rsv) else $error("reserved rate accepted");

    property p_ratio;
        (ratio_code == 4'hC) |-> ratio == 12'h800;
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio code 12 wrong");

    property p_ignore;
        (!role && !auto_off) |=> !cfg_invalid;
    endproperty
    a_ignore: assert property (p_ignore) else $error("fields checked in target auto");

    property p_spec;
        (role && master_clock_spec_mode) |=> pll_ref_hz == $past(spec_hz);
    endproperty
    a_spec: assert property (p_spec) else $error("spec mode reference wrong");

    sequence s_last_tick;
        role && gen_en && bit_tick && st_r == ASC_RUN && last_bit;
    endsequence
    property p_frame;
        s_last_tick |=> cnt_r == 12'h000 && fsync_gen_r == (format_is_tdm || half != 12'h000);
    endproperty
    a_frame: assert property (p_frame) else $error("frame length not ratio");
endmodule
`default_nettype wire

// File: verification/asc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side host: samples the data line on the bit clock rising edge
module asc_host_model
(
    input  wire logic   core_clk,
    input  wire logic   gen_en,
    input  wire logic   ctl_bclk,
    input  wire logic   ctl_fsync,
    input  wire logic   sd,
    input  wire logic   sd_oe,
    output logic        bclk_in,
    output logic        fsync_in,
    output logic [31:0] word_q,
    output int          bits,
    output int          first,
    output int          frames
);
    logic        bck;
    logic        fs;
    logic        fs_d = 1'b0;
    logic        seen = 1'b0;
    logic [31:0] word = 32'h0;
    int          cnt = 0;
    int          div = 0;
    int          gbit = 0;

    initial
    begin
        bclk_in = 1'b0;
        fsync_in = 1'b0;
        frames = 0;
    end
    // clocks come from this side only while the device is a target
    assign bck = gen_en ? bclk_in : ctl_bclk;
    assign fs  = gen_en ? fsync_in : ctl_fsync;
    // clock stands still when idle; slow enough for the input synchroniser
    always @(posedge core_clk)
    begin
        div = (div + 1) % 8;
        if (!gen_en)
            bclk_in <= 1'b0;
        else if (div == 0)
            bclk_in <= ~bclk_in;
        if (gen_en && div == 0 && bclk_in)
        begin
            gbit = (gbit + 1) % 64;
            fsync_in <= (gbit == 0);
        end
    end
    // frame start on a rising fsync; word latched before the next shift
    always @(posedge bck)
    begin
        if (fs && !fs_d)
        begin
            bits = cnt;
            word_q = word;
            cnt = 0;
            seen = 1'b0;
            frames++;
        end
        if (sd_oe === 1'b1)
        begin
            if (!seen)
                first = cnt;
            seen = 1'b1;
            word = {word[30:0], sd};
        end
        cnt++;
        fs_d = fs;
    end
endmodule
`default_nettype wire

// File: verification/asc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module asc_top_bench;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic        smp_valid = 1'b0;
    logic [31:0] smp_data = 32'h0;
    logic        tdm = 1'b1;
    logic        spec = 1'b0;
    logic [2:0]  mratio = 3'h1;
    logic        gen_en = 1'b0;
    logic [7:0]  reg_rdata;
    logic [31:0] pll_ref_hz, wq;
    logic        smp_ready, bclk_in, fsync_in, bclk_out, bclk_oe, fsync_out, fsync_oe;
    logic        po, poe, go, goe, pll_enable, custom_clock_mode, cfg_invalid;
    int          fails = 0;
    int          check_count = 0;
    int          m [3] = '{7, 2, 72};
    int          bad = 0;
    int          edges = 0;
    int          bits, first, frames, e, f;
    bit          line1 = 0;
    logic [31:0] q [$];
    int          mclk [8] = '{12000000, 12288000, 13000000, 16000000,
                              19200000, 19680000, 24000000, 24576000};
    logic [16:0] inv_t [5] = '{{8'h82, 8'h98, 1'b1}, {8'h82, 8'h6D, 1'b1},
                               {8'h02, 8'hF8, 1'b0}, {8'h42, 8'h98, 1'b1},
                               {8'h82, 8'h68, 1'b0}};
    logic [32:0] fr_t [4] = '{{1'b1, 8'h00, 4'h2, 8'h00, 12'h020},
                              {1'b1, 8'h01, 4'h4, 8'h20, 12'h040},
                              {1'b0, 8'h21, 4'h6, 8'h60, 12'h080},
                              {1'b1, 8'h43, 4'h6, 8'h60, 12'h080}};

    always #5 core_clk = ~core_clk;
    wire logic   wire_sd;
    // data reaches the host from whichever line is enabled
    assign wire_sd = poe ? po : go;
    asc_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
        .format_is_tdm(tdm), .master_clock_spec_mode(spec),
        .mclk_frame_ratio_code(mratio), .bclk_in(bclk_in), .fsync_in(fsync_in),
        .bclk_out(bclk_out), .bclk_oe(bclk_oe), .fsync_out(fsync_out),
        .fsync_oe(fsync_oe), .primary_serial_out_pin(po), .primary_oe(poe),
        .general_io_pin_one_out(go), .general_io_pin_one_oe(goe),
        .pll_enable(pll_enable), .custom_clock_mode(custom_clock_mode),
        .cfg_invalid(cfg_invalid), .pll_ref_hz(pll_ref_hz));
    asc_host_model host (.core_clk(core_clk), .gen_en(gen_en), .ctl_bclk(bclk_out),
        .ctl_fsync(fsync_out), .sd(wire_sd), .sd_oe(poe | goe), .bclk_in(bclk_in),
        .fsync_in(fsync_in), .word_q(wq), .bits(bits), .first(first), .frames(frames));
    // generated clock edges, and data seen on the unselected line
    always @(posedge bclk_out)
        edges++;
    always @(negedge core_clk)
    begin
        if ((line1 ? poe : goe) === 1'b1)
            bad++;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, x, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // strobe one edge, then two idle edges so back-to-back calls never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(2);
        if (a >= 8'h12 && a <= 8'h14)
            m[a - 8'h12] = (a == 8'h12) ? (d & 8'h7F) : d;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
        chk("reg_rdata", {24'h0, reg_rdata}, (a >= 8'h12 && a <= 8'h14) ? m[a - 8'h12] : 0);
    endtask
    task automatic wf(input int n);
        int t;
        t = frames + n;
        for (int i = 0; i < 30000 && frames < t; i++)
            cyc(1);
        if (frames < t)
        begin
            fails++;
            $display("[ERR] frame_count expected %0d seen %0d", t, frames);
            test_done;
        end
    endtask
    task automatic push(input logic [31:0] d);
        chk("smp_ready", smp_ready, 1);
        smp_data <= d;
        smp_valid <= 1'b1;
        cyc(1);
        smp_valid <= 1'b0;
        cyc(1);
        q.push_back(d);
    endtask

    initial
    begin
        e = $urandom(45);
        cyc(3);
        rst <= 1'b0;
        cyc(1);
        for (int a = 8'h11; a <= 8'h15; a++)
            rd(8'(a));
        chk("pll_enable", pll_enable, 1);
        chk("custom_clock_mode", custom_clock_mode, 0);
        chk("bclk_oe", bclk_oe, 0);
        for (int i = 0; i < 6; i++)
        begin
            f = 8'h12 + $urandom % 4;
            wr(8'(f), 8'($urandom));
            rd(8'(f));
        end
        $display("test registers done");
        for (int b = 0; b < 4; b++)
        begin
            wr(8'h13, {1'b0, 2'(b), 5'h02});
            chk("custom_clock_mode", custom_clock_mode, b / 2);
            chk("pll_enable", pll_enable, b == 0);
        end
        wr(8'h14, 8'h48);
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h13, 8'h80 | 8'(c));
            chk("pll_ref_hz", pll_ref_hz, mclk[c]);
        end
        spec <= 1'b1;
        wr(8'h13, 8'h82);
        chk("pll_ref_hz", pll_ref_hz, 48000 * 256);
        wr(8'h13, 8'h8A);
        chk("pll_ref_hz", pll_ref_hz, 48000 * 147 / 160 * 256);
        spec <= 1'b0;
        $display("test clock config done");
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h13, inv_t[i][16:9]);
            wr(8'h14, inv_t[i][8:1]);
            cyc(4);
            e = edges;
            chk("cfg_invalid", cfg_invalid, inv_t[i][0]);
            cyc(100);
            if (inv_t[i][0])
                chk("bclk_edges", edges - e, 0);
        end
        $display("test reserved codes done");
        wr(8'h13, 8'h82);
        for (int i = 0; i < 4; i++)
        begin
            tdm <= fr_t[i][32];
            line1 = fr_t[i][30];
            wr(8'h12, fr_t[i][31:24]);
            wr(8'h14, {4'h5, fr_t[i][23:20]});
            wf(2);
            bad = 0;
            push($urandom);
            wf(2);
            chk("frame_bits", bits, fr_t[i][11:0]);
            chk("slot_start", first, fr_t[i][19:12]);
            chk("slot_word", wq, q.pop_front());
            chk("wrong_line", bad, 0);
        end
        $display("test framing done");
        wr(8'h13, 8'h92);
        cyc(4);
        e = edges;
        f = frames;
        cyc(300);
        chk("bclk_edges", edges - e, 0);
        chk("fsync_frames", frames - f, 0);
        chk("bclk_oe", bclk_oe, 1);
        chk("fsync_oe", fsync_oe, 1);
        $display("test gate done");
        wr(8'h13, 8'h02);
        wr(8'h12, 8'h01);
        line1 = 0;
        for (int i = 0; i < 8; i++)
            push($urandom);
        chk("smp_ready", smp_ready, 0);
        smp_data <= 32'hFFFFFFFF;
        smp_valid <= 1'b1;
        cyc(3);
        smp_valid <= 1'b0;
        q.push_back(32'h0);
        gen_en <= 1'b1;
        wf(1);
        for (int i = 0; i < 9; i++)
        begin
            wf(1);
            chk("target_word", wq, q.pop_front());
            chk("bclk_oe", bclk_oe, 0);
        end
        chk("smp_ready", smp_ready, 1);
        chk("frame_bits", bits, 64);
        $display("test target fifo done");
        test_done;
    end
endmodule
`default_nettype wire
